// [hdl/cbf_pkg.sv]
// Package: opcodes, status flag positions, cycle counts and the request carrier
package cbf_pkg;
    localparam int DATA_W = 8;
    localparam int REG_IDX_W = 5;
    localparam int IO_ADDR_W = 6;
    localparam int BIT_IDX_W = 3;
    localparam int SP_W = 16;
    localparam logic [SP_W-1:0] SP_RESET = 16'h0000;

    // Status flag bit positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;
    localparam logic [DATA_W-1:0] FLAGS_RESET = 8'h00;

    localparam int MSB = DATA_W - 1;
    localparam int NIB = DATA_W / 2;
    localparam logic [SP_W-1:0] SP_STEP = 16'h0001;

    // Execution cycle counts
    localparam int CYC_SHORT = 1;
    localparam int CYC_LONG = 2;

    typedef enum logic [4:0] {
        OP_NOP = 5'h00,
        OP_IN = 5'h01,
        OP_OUT = 5'h02,
        OP_PUSH = 5'h03,
        OP_POP = 5'h04,
        OP_IO_BIT_SET = 5'h05,
        OP_IO_BIT_CLEAR = 5'h06,
        OP_LOGICAL_LEFT_SHIFT = 5'h07,
        OP_LOGICAL_RIGHT_SHIFT = 5'h08,
        OP_ROTATE_LEFT_VIA_CARRY = 5'h09,
        OP_ROTATE_RIGHT_VIA_CARRY = 5'h0A,
        OP_ARITH_SHIFT_RIGHT = 5'h0B,
        OP_NIBBLE_SWAP = 5'h0C,
        OP_FLAG_SET = 5'h0D,
        OP_FLAG_CLEAR = 5'h0E,
        OP_BIT_TO_FLAG_STORE = 5'h0F,
        OP_FLAG_TO_BIT_LOAD = 5'h10,
        OP_SLEEP = 5'h11,
        OP_WATCHDOG_RESTART = 5'h12,
        OP_BREAK = 5'h13
    } cbf_op_t;

    typedef struct packed {
        cbf_op_t op;
        logic [REG_IDX_W-1:0] reg_idx;
        logic [IO_ADDR_W-1:0] io_addr;
        logic [BIT_IDX_W-1:0] bit_idx;
    } cbf_instr_t;

    typedef struct packed {
        logic we;
        logic [REG_IDX_W-1:0] idx;
        logic [DATA_W-1:0] data;
    } cbf_reg_wr_t;

    typedef struct packed {
        logic we;
        logic [IO_ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } cbf_io_wr_t;
endpackage

// [hdl/cbf_shifter.sv]
// Shift, rotate and nibble swap unit with its flag results
`timescale 1ns/10ps
`default_nettype none
module cbf_shifter #(
    parameter int W = 8
) (
    input wire cbf_pkg::cbf_op_t op,
    input wire logic [W-1:0] din,
    input wire logic [W-1:0] flags_in,
    output logic [W-1:0] dout,
    output logic [W-1:0] flags_out
);
    logic [W-1:0] f;
    logic carry;

    initial begin
        if (W != cbf_pkg::DATA_W) begin
            $error("cbf_shifter needs W equal to DATA_W");
        end
    end

    always_comb begin
        f = flags_in;
        carry = flags_in[cbf_pkg::FLAG_C];
        dout = din;
        case (op)
            cbf_pkg::OP_LOGICAL_LEFT_SHIFT: begin
                dout = {din[W-2:0], 1'b0};
                carry = din[W-1];
            end
            cbf_pkg::OP_LOGICAL_RIGHT_SHIFT: begin
                dout = {1'b0, din[W-1:1]};
                carry = din[0];
            end
            cbf_pkg::OP_ROTATE_LEFT_VIA_CARRY: begin
                dout = {din[W-2:0], flags_in[cbf_pkg::FLAG_C]};
                carry = din[W-1];
            end
            cbf_pkg::OP_ROTATE_RIGHT_VIA_CARRY: begin
                dout = {flags_in[cbf_pkg::FLAG_C], din[W-1:1]};
                carry = din[0];
            end
            cbf_pkg::OP_ARITH_SHIFT_RIGHT: begin
                dout = {din[W-1], din[W-1:1]};
                carry = din[0];
            end
            cbf_pkg::OP_NIBBLE_SWAP: begin
                dout = {din[W/2-1:0], din[W-1:W/2]};
            end
            default: begin
                dout = din;
            end
        endcase
        if (op inside {cbf_pkg::OP_LOGICAL_LEFT_SHIFT, cbf_pkg::OP_LOGICAL_RIGHT_SHIFT,
                cbf_pkg::OP_ROTATE_LEFT_VIA_CARRY, cbf_pkg::OP_ROTATE_RIGHT_VIA_CARRY,
                cbf_pkg::OP_ARITH_SHIFT_RIGHT}) begin
            // V is N xor C after the shift; S follows N xor V
            f[cbf_pkg::FLAG_C] = carry;
            f[cbf_pkg::FLAG_Z] = (dout == '0);
            f[cbf_pkg::FLAG_N] = dout[W-1];
            f[cbf_pkg::FLAG_V] = dout[W-1] ^ carry;
            f[cbf_pkg::FLAG_S] = dout[W-1] ^ dout[W-1] ^ carry;
        end
        flags_out = f;
    end
endmodule
`default_nettype wire

// [hdl/cbf_regfile.sv]
// Working register file with one write port and two read ports
`timescale 1ns/10ps
`default_nettype none
module cbf_regfile #(
    parameter int W = 8,
    parameter int N = 32
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire cbf_pkg::cbf_reg_wr_t wr,
    input wire logic [$clog2(N)-1:0] rd_idx,
    output logic [W-1:0] rd_data,
    input wire logic [$clog2(N)-1:0] dbg_idx,
    output logic [W-1:0] dbg_data
);
    logic [W-1:0] regs_ff [N];

    initial begin
        if (N != (1 << cbf_pkg::REG_IDX_W)) begin
            $error("cbf_regfile needs N to match REG_IDX_W");
        end
    end

    // Array kept without reset so it maps to plain storage
    always_ff @(posedge clk_sys) begin
        if (wr.we) begin
            regs_ff[wr.idx] <= wr.data;
        end
    end

    assign rd_data = regs_ff[rd_idx];
    assign dbg_data = regs_ff[dbg_idx];
endmodule
`default_nettype wire

// [hdl/cbf_core.sv]
// Execution of port, stack, bit, shift, flag and MCU control instructions
//
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/10ps
`default_nettype none
module cbf_core #(
    parameter int W = 8,
    parameter int NREGS = 32
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic instr_valid,
    input wire cbf_pkg::cbf_instr_t instr,
    output logic instr_ready,
    output logic done,
    output cbf_pkg::cbf_io_wr_t io_wr,
    output logic [cbf_pkg::IO_ADDR_W-1:0] io_rd_addr,
    input wire logic [W-1:0] io_rd_data,
    output logic [cbf_pkg::SP_W-1:0] mem_addr,
    output logic mem_we,
    output logic [W-1:0] mem_wdata,
    input wire logic [W-1:0] mem_rdata,
    output logic [W-1:0] status_flags_register,
    output logic [cbf_pkg::SP_W-1:0] stack_ptr,
    output logic sleep_req,
    output logic watchdog_restart,
    output logic break_req,
    input wire logic [cbf_pkg::REG_IDX_W-1:0] dbg_idx,
    output logic [W-1:0] dbg_data
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SECOND = 2'b01
    } cbf_state_t;

    cbf_state_t state_ff, nxt_state;
    cbf_pkg::cbf_instr_t held_ff, nxt_held;
    logic [W-1:0] flags_ff, nxt_flags;
    logic [cbf_pkg::SP_W-1:0] sp_ff, nxt_sp;
    logic done_ff, nxt_done;
    logic sleep_ff, nxt_sleep;
    logic wdr_ff, nxt_wdr;
    logic brk_ff, nxt_brk;
    cbf_pkg::cbf_io_wr_t io_wr_ff, nxt_io_wr;
    logic [cbf_pkg::SP_W-1:0] mem_addr_ff, nxt_mem_addr;
    logic mem_we_ff, nxt_mem_we;
    logic [W-1:0] mem_wdata_ff, nxt_mem_wdata;
    cbf_pkg::cbf_reg_wr_t rf_wr;
    logic [W-1:0] rf_rd;
    logic [W-1:0] sh_dout, sh_flags;
    logic [cbf_pkg::REG_IDX_W-1:0] rf_idx;
    cbf_pkg::cbf_instr_t cur;

    initial begin
        if (W != cbf_pkg::DATA_W || NREGS != (1 << cbf_pkg::REG_IDX_W)) begin
            $error("cbf_core parameters do not match the package widths");
        end
    end

    function automatic logic [W-1:0] put_bit(input logic [W-1:0] v,
            input logic [cbf_pkg::BIT_IDX_W-1:0] b, input logic x);
        logic [W-1:0] r;
        r = v;
        r[b] = x;
        return r;
    endfunction

    function automatic logic is_two_cycle(input cbf_pkg::cbf_op_t op);
        return op inside {cbf_pkg::OP_PUSH, cbf_pkg::OP_POP,
            cbf_pkg::OP_IO_BIT_SET, cbf_pkg::OP_IO_BIT_CLEAR};
    endfunction

    assign cur = (state_ff == ST_SECOND) ? held_ff : instr;
    assign rf_idx = cur.reg_idx;
    assign instr_ready = (state_ff == ST_IDLE);
    assign io_rd_addr = cur.io_addr;

    cbf_regfile #(
        .W(W),
        .N(NREGS)
    ) u_regs (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .wr(rf_wr),
        .rd_idx(rf_idx),
        .rd_data(rf_rd),
        .dbg_idx(dbg_idx),
        .dbg_data(dbg_data)
    );

    cbf_shifter #(
        .W(W)
    ) u_shift (
        .op(instr.op),
        .din(rf_rd),
        .flags_in(flags_ff),
        .dout(sh_dout),
        .flags_out(sh_flags)
    );

    always_comb begin
        nxt_state = state_ff;
        nxt_held = held_ff;
        nxt_flags = flags_ff;
        nxt_sp = sp_ff;
        nxt_done = 1'b0;
        nxt_sleep = 1'b0;
        nxt_wdr = 1'b0;
        nxt_brk = 1'b0;
        nxt_io_wr = '0;
        nxt_mem_addr = mem_addr_ff;
        nxt_mem_we = 1'b0;
        nxt_mem_wdata = mem_wdata_ff;
        rf_wr = '0;
        rf_wr.idx = cur.reg_idx;
        case (state_ff)
            ST_IDLE: begin
                if (instr_valid) begin
                    nxt_held = instr;
                    if (is_two_cycle(instr.op)) begin
                        nxt_state = ST_SECOND;
                    end else begin
                        nxt_done = 1'b1;
                    end
                    case (instr.op)
                        cbf_pkg::OP_IN: begin
                            rf_wr.we = 1'b1;
                            rf_wr.data = io_rd_data;
                        end
                        cbf_pkg::OP_OUT: begin
                            nxt_io_wr = '{we: 1'b1, addr: instr.io_addr, data: rf_rd};
                        end
                        cbf_pkg::OP_PUSH: begin
                            // Post-decrement: store at pointer, then move down
                            nxt_mem_addr = sp_ff;
                            nxt_mem_we = 1'b1;
                            nxt_mem_wdata = rf_rd;
                            nxt_sp = sp_ff - cbf_pkg::SP_STEP;
                        end
                        cbf_pkg::OP_POP: begin
                            nxt_sp = sp_ff + cbf_pkg::SP_STEP;
                            nxt_mem_addr = sp_ff + cbf_pkg::SP_STEP;
                        end
                        cbf_pkg::OP_LOGICAL_LEFT_SHIFT, cbf_pkg::OP_LOGICAL_RIGHT_SHIFT,
                        cbf_pkg::OP_ROTATE_LEFT_VIA_CARRY, cbf_pkg::OP_ROTATE_RIGHT_VIA_CARRY,
                        cbf_pkg::OP_ARITH_SHIFT_RIGHT, cbf_pkg::OP_NIBBLE_SWAP: begin
                            rf_wr.we = 1'b1;
                            rf_wr.data = sh_dout;
                            nxt_flags = sh_flags;
                        end
                        cbf_pkg::OP_FLAG_SET: begin
                            // Covers S, V, H, I and the rest by bit index
                            nxt_flags = put_bit(flags_ff, instr.bit_idx, 1'b1);
                        end
                        cbf_pkg::OP_FLAG_CLEAR: begin
                            nxt_flags = put_bit(flags_ff, instr.bit_idx, 1'b0);
                        end
                        cbf_pkg::OP_BIT_TO_FLAG_STORE: begin
                            nxt_flags[cbf_pkg::FLAG_T] = rf_rd[instr.bit_idx];
                        end
                        cbf_pkg::OP_FLAG_TO_BIT_LOAD: begin
                            rf_wr.we = 1'b1;
                            rf_wr.data = put_bit(rf_rd, instr.bit_idx,
                                flags_ff[cbf_pkg::FLAG_T]);
                        end
                        cbf_pkg::OP_SLEEP: begin
                            nxt_sleep = 1'b1;
                        end
                        cbf_pkg::OP_WATCHDOG_RESTART: begin
                            nxt_wdr = 1'b1;
                        end
                        cbf_pkg::OP_BREAK: begin
                            nxt_brk = 1'b1;
                        end
                        default: begin
                            nxt_held = instr;
                        end
                    endcase
                end
            end
            ST_SECOND: begin
                nxt_state = ST_IDLE;
                nxt_done = 1'b1;
                case (held_ff.op)
                    cbf_pkg::OP_POP: begin
                        rf_wr.we = 1'b1;
                        rf_wr.data = mem_rdata;
                    end
                    cbf_pkg::OP_IO_BIT_SET: begin
                        nxt_io_wr = '{we: 1'b1, addr: held_ff.io_addr,
                            data: put_bit(io_rd_data, held_ff.bit_idx, 1'b1)};
                    end
                    cbf_pkg::OP_IO_BIT_CLEAR: begin
                        nxt_io_wr = '{we: 1'b1, addr: held_ff.io_addr,
                            data: put_bit(io_rd_data, held_ff.bit_idx, 1'b0)};
                    end
                    default: begin
                        nxt_done = 1'b1;
                    end
                endcase
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_IDLE;
            held_ff <= '0;
            flags_ff <= cbf_pkg::FLAGS_RESET;
            sp_ff <= cbf_pkg::SP_RESET;
            done_ff <= 1'b0;
            sleep_ff <= 1'b0;
            wdr_ff <= 1'b0;
            brk_ff <= 1'b0;
            io_wr_ff <= '0;
            mem_addr_ff <= cbf_pkg::SP_RESET;
            mem_we_ff <= 1'b0;
            mem_wdata_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            held_ff <= nxt_held;
            flags_ff <= nxt_flags;
            sp_ff <= nxt_sp;
            done_ff <= nxt_done;
            sleep_ff <= nxt_sleep;
            wdr_ff <= nxt_wdr;
            brk_ff <= nxt_brk;
            io_wr_ff <= nxt_io_wr;
            mem_addr_ff <= nxt_mem_addr;
            mem_we_ff <= nxt_mem_we;
            mem_wdata_ff <= nxt_mem_wdata;
        end
    end

    assign done = done_ff;
    assign io_wr = io_wr_ff;
    assign mem_addr = mem_addr_ff;
    assign mem_we = mem_we_ff;
    assign mem_wdata = mem_wdata_ff;
    assign status_flags_register = flags_ff;
    assign stack_ptr = sp_ff;
    assign sleep_req = sleep_ff;
    assign watchdog_restart = wdr_ff;
    assign break_req = brk_ff;

    logic accept;
    assign accept = instr_valid && instr_ready;

    a_push_timing: assert property (@(posedge clk_sys) disable iff (!rst_n)
        accept && instr.op == cbf_pkg::OP_PUSH |-> ##1 mem_we && !done ##1 done
            && $stable(status_flags_register))
        else $error("push timing wrong");
    a_pop_sp: assert property (@(posedge clk_sys) disable iff (!rst_n)
        accept && instr.op == cbf_pkg::OP_POP |=> stack_ptr == $past(stack_ptr) + 16'h0001
            ##1 done && $stable(status_flags_register))
        else $error("pop pointer or timing wrong");
    a_bit_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_ff == ST_SECOND && held_ff.op == cbf_pkg::OP_IO_BIT_SET |=> io_wr.we
            && io_wr.data[$past(held_ff.bit_idx)] && done)
        else $error("io bit set wrong");
    a_bit_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_ff == ST_SECOND && held_ff.op == cbf_pkg::OP_IO_BIT_CLEAR |=> io_wr.we
            && !io_wr.data[$past(held_ff.bit_idx)] && done)
        else $error("io bit clear wrong");
    a_shift_carry: assert property (@(posedge clk_sys) disable iff (!rst_n)
        accept && instr.op == cbf_pkg::OP_LOGICAL_LEFT_SHIFT |=> done
            && status_flags_register[cbf_pkg::FLAG_C] == $past(rf_rd[cbf_pkg::MSB]))
        else $error("left shift carry wrong");
    a_rol_carry: assert property (@(posedge clk_sys) disable iff (!rst_n)
        accept && instr.op == cbf_pkg::OP_ROTATE_LEFT_VIA_CARRY
            |-> sh_dout[0] == status_flags_register[cbf_pkg::FLAG_C])
        else $error("rotate left wrong");
    a_ror_carry: assert property (@(posedge clk_sys) disable iff (!rst_n)
        accept && instr.op == cbf_pkg::OP_ROTATE_RIGHT_VIA_CARRY
            |=> status_flags_register[cbf_pkg::FLAG_C] == $past(rf_rd[0]))
        else $error("rotate right carry wrong");
    a_asr_sign: assert property (@(posedge clk_sys) disable iff (!rst_n)
        accept && instr.op == cbf_pkg::OP_ARITH_SHIFT_RIGHT
            |-> sh_dout[cbf_pkg::MSB] == rf_rd[cbf_pkg::MSB])
        else $error("arith shift lost sign");
    a_bst_only_t: assert property (@(posedge clk_sys) disable iff (!rst_n)
        accept && instr.op == cbf_pkg::OP_BIT_TO_FLAG_STORE |=>
            status_flags_register[cbf_pkg::FLAG_T] == $past(rf_rd[instr.bit_idx])
            && status_flags_register[5:0] == $past(status_flags_register[5:0]))
        else $error("bit store wrong");
    a_flag_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
        accept && instr.op == cbf_pkg::OP_FLAG_SET |=>
            status_flags_register == ($past(status_flags_register)
            | (8'h01 << $past(instr.bit_idx))))
        else $error("flag set touched other bits");
    a_sleep_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
        accept && instr.op == cbf_pkg::OP_SLEEP |=> sleep_req && done ##1 !sleep_req)
        else $error("sleep pulse wrong");
    a_wdr_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
        accept && instr.op == cbf_pkg::OP_WATCHDOG_RESTART |=> watchdog_restart
            && $stable(status_flags_register))
        else $error("watchdog restart wrong");

    c_push: cover property (@(posedge clk_sys) accept && instr.op == cbf_pkg::OP_PUSH);
    c_pop: cover property (@(posedge clk_sys) accept && instr.op == cbf_pkg::OP_POP);
    c_bit_set: cover property (@(posedge clk_sys) accept && instr.op == cbf_pkg::OP_IO_BIT_SET);
    c_rotate: cover property (@(posedge clk_sys)
        accept && instr.op == cbf_pkg::OP_ROTATE_RIGHT_VIA_CARRY);
endmodule
`default_nettype wire

// [sim/cbf_core_tb_top.sv]
// Self-checking bench for the bit, shift, flag, stack and control execution block
`timescale 1ns/10ps
`default_nettype none
module cbf_core_tb_top;
    logic clk_sys;
    logic rst_n;
    logic instr_valid;
    cbf_pkg::cbf_instr_t instr;
    logic instr_ready;
    logic done;
    cbf_pkg::cbf_io_wr_t io_wr;
    logic [5:0] io_rd_addr;
    logic [7:0] io_rd_data;
    logic [15:0] mem_addr;
    logic mem_we;
    logic [7:0] mem_wdata;
    logic [7:0] mem_rdata;
    logic [7:0] flags;
    logic [15:0] stack_ptr;
    logic sleep_req;
    logic watchdog_restart;
    logic break_req;
    logic [4:0] dbg_idx;
    logic [7:0] dbg_data;
    logic [7:0] io_mem [0:63];
    logic [7:0] ram [0:255];
    logic [2:0] pulses;
    int n;
    int failures = 0;
    int checks_done = 0;

    cbf_core dut (.clk_sys(clk_sys), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr),
        .instr_ready(instr_ready), .done(done), .io_wr(io_wr), .io_rd_addr(io_rd_addr),
        .io_rd_data(io_rd_data), .mem_addr(mem_addr), .mem_we(mem_we), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .status_flags_register(flags), .stack_ptr(stack_ptr),
        .sleep_req(sleep_req), .watchdog_restart(watchdog_restart), .break_req(break_req),
        .dbg_idx(dbg_idx), .dbg_data(dbg_data));

    // Port space and stack memory answer in the same cycle
    assign io_rd_data = io_mem[io_rd_addr];
    assign mem_rdata = ram[mem_addr[7:0]];
    always @(posedge clk_sys) begin
        if (io_wr.we === 1'b1) io_mem[io_wr.addr] <= io_wr.data;
        if (mem_we === 1'b1) ram[mem_addr[7:0]] <= mem_wdata;
    end

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic test_done;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Holds the request until accepted, then counts cycles to completion
    task automatic run(input cbf_pkg::cbf_op_t op, input logic [4:0] r, input logic [5:0] a,
            input logic [2:0] b);
        @(posedge clk_sys);
        instr_valid <= 1'b1;
        instr <= '{op, r, a, b};
        n = 0;
        @(negedge clk_sys);
        while (instr_ready !== 1'b1 && n < 8) begin
            @(negedge clk_sys);
            n++;
        end
        @(posedge clk_sys);
        instr_valid <= 1'b0;
        n = 0;
        pulses = 3'b000;
        do begin
            @(negedge clk_sys);
            n++;
            pulses |= {sleep_req, watchdog_restart, break_req};
        end while (done !== 1'b1 && n < 8);
    endtask

    task automatic rd(input logic [4:0] r, output logic [7:0] v);
        @(posedge clk_sys);
        dbg_idx <= r;
        @(negedge clk_sys);
        v = dbg_data;
    endtask

    task automatic load(input logic [4:0] r, input logic [7:0] v);
        io_mem[1] = v;
        run(cbf_pkg::OP_IN, r, 6'h01, 3'h0);
    endtask

    function automatic logic [8:0] shf(input cbf_pkg::cbf_op_t op, input logic [7:0] d,
            input logic c);
        case (op)
            cbf_pkg::OP_LOGICAL_LEFT_SHIFT: return {d[7], d[6:0], 1'b0};
            cbf_pkg::OP_LOGICAL_RIGHT_SHIFT: return {d[0], 1'b0, d[7:1]};
            cbf_pkg::OP_ROTATE_LEFT_VIA_CARRY: return {d[7], d[6:0], c};
            cbf_pkg::OP_ROTATE_RIGHT_VIA_CARRY: return {d[0], c, d[7:1]};
            default: return {d[0], d[7], d[7:1]};
        endcase
    endfunction

    cbf_pkg::cbf_op_t sops [5] = '{cbf_pkg::OP_LOGICAL_LEFT_SHIFT,
        cbf_pkg::OP_LOGICAL_RIGHT_SHIFT, cbf_pkg::OP_ROTATE_LEFT_VIA_CARRY,
        cbf_pkg::OP_ROTATE_RIGHT_VIA_CARRY, cbf_pkg::OP_ARITH_SHIFT_RIGHT};
    logic [7:0] vals [2] = '{8'h81, 8'h01};
    logic [7:0] v;
    logic [7:0] fl;
    logic [7:0] e;
    logic [8:0] r;

    initial begin
        #20000;
        failures++;
        test_done();
    end

    initial begin
        rst_n = 1'b0;
        instr_valid = 1'b0;
        instr = '0;
        dbg_idx = 5'h00;
        for (int i = 0; i < 64; i++) io_mem[i] = 8'h00;
        for (int i = 0; i < 256; i++) ram[i] = 8'h00;
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(negedge clk_sys);
        check(flags, 8'h00);
        check(stack_ptr, 16'h0000);
        check(instr_ready, 1'b1);
        $display("test reset done");
        // Carry in alternates so both rotate inputs are seen
        for (int k = 0; k < 2; k++) begin
            foreach (sops[j]) begin
                load(5'h02, vals[k]);
                run(k ? cbf_pkg::OP_FLAG_CLEAR : cbf_pkg::OP_FLAG_SET, 5'h00, 6'h00, 3'h0);
                fl = flags;
                run(sops[j], 5'h02, 6'h00, 3'h0);
                check(n, 1);
                r = shf(sops[j], vals[k], fl[0]);
                rd(5'h02, v);
                check(v, r[7:0]);
                e = fl;
                e[0] = r[8];
                e[1] = (r[7:0] == 8'h00);
                e[2] = r[7];
                e[3] = r[7] ^ r[8];
                check(flags & 8'hEF, e & 8'hEF);
            end
        end
        $display("test shifts done");
        load(5'h02, 8'h3C);
        fl = flags;
        run(cbf_pkg::OP_NIBBLE_SWAP, 5'h02, 6'h00, 3'h0);
        rd(5'h02, v);
        check({n[7:0], v, flags}, {8'h01, 8'hC3, fl});
        // Every flag on, then every flag off, one at a time
        for (int b = 0; b < 8; b++) begin
            fl = flags;
            run(cbf_pkg::OP_FLAG_SET, 5'h00, 6'h00, b[2:0]);
            check({n[7:0], flags}, {8'h01, fl | (8'h01 << b)});
        end
        for (int b = 0; b < 8; b++) begin
            fl = flags;
            run(cbf_pkg::OP_FLAG_CLEAR, 5'h00, 6'h00, b[2:0]);
            check({n[7:0], flags}, {8'h01, fl & ~(8'h01 << b)});
        end
        $display("test flags done");
        load(5'h02, 8'h04);
        fl = flags;
        run(cbf_pkg::OP_BIT_TO_FLAG_STORE, 5'h02, 6'h00, 3'h2);
        check({n[7:0], flags}, {8'h01, fl | 8'h40});
        load(5'h05, 8'h00);
        fl = flags;
        run(cbf_pkg::OP_FLAG_TO_BIT_LOAD, 5'h05, 6'h00, 3'h7);
        rd(5'h05, v);
        check({n[7:0], v, flags}, {8'h01, 8'h80, fl});
        $display("test transfer flag done");
        load(5'h03, 8'hC3);
        fl = flags;
        run(cbf_pkg::OP_PUSH, 5'h03, 6'h00, 3'h0);
        check({n[7:0], ram[0], flags}, {8'h02, 8'hC3, fl});
        check(stack_ptr, 16'hFFFF);
        run(cbf_pkg::OP_POP, 5'h04, 6'h00, 3'h0);
        rd(5'h04, v);
        check({n[7:0], v, flags}, {8'h02, 8'hC3, fl});
        check(stack_ptr, 16'h0000);
        $display("test stack done");
        io_mem[3] = 8'h5A;
        run(cbf_pkg::OP_IO_BIT_SET, 5'h00, 6'h03, 3'h0);
        // The port write lands one edge after done, so the write itself is compared
        check({n[7:0], io_wr, flags}, {8'h02, 1'b1, 6'h03, 8'h5B, fl});
        run(cbf_pkg::OP_IO_BIT_CLEAR, 5'h00, 6'h03, 3'h6);
        check({n[7:0], io_wr, flags}, {8'h02, 1'b1, 6'h03, 8'h1B, fl});
        $display("test io bits done");
        run(cbf_pkg::OP_SLEEP, 5'h00, 6'h00, 3'h0);
        check({n[7:0], pulses, flags}, {8'h01, 3'b100, fl});
        run(cbf_pkg::OP_WATCHDOG_RESTART, 5'h00, 6'h00, 3'h0);
        check({n[7:0], pulses, flags}, {8'h01, 3'b010, fl});
        // No cycle count is fixed for a break, so only its effects are compared
        run(cbf_pkg::OP_BREAK, 5'h00, 6'h00, 3'h0);
        check({pulses, flags}, {3'b001, fl});
        $display("test control done");
        test_done();
    end
endmodule
`default_nettype wire
